// ===== src/bdc_pkg.sv
package bdc_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] BDC_OFS_INIT = 8'h00;
    localparam logic [7:0] BDC_OFS_CUR  = 8'h04;
    localparam logic [7:0] BDC_OFS_CMD  = 8'h08;
    localparam logic [7:0] BDC_OFS_IST  = 8'h0C;
    localparam logic [7:0] BDC_OFS_IMSK = 8'h10;
    localparam logic [7:0] BDC_OFS_CFG  = 8'h14;

    // Request source codes.
    localparam logic [1:0] BDC_SRC_NONE  = 2'h0;
    localparam logic [1:0] BDC_SRC_TIMER = 2'h1;
    localparam logic [1:0] BDC_SRC_UART  = 2'h2;
    localparam logic [1:0] BDC_SRC_SYNC  = 2'h3;

    // Fixed mode fields of the control word.
    localparam logic [1:0] BDC_HANDSHAKE_MODE = 2'h0;
    localparam logic [1:0] BDC_UNIT_MODE      = 2'h1;
    localparam logic [1:0] BDC_NO_FLY_MODE    = 2'h0;

    // Interrupt mode codes.
    localparam logic [1:0] BDC_INT_POLL = 2'h0;
    localparam logic [1:0] BDC_INT_EACH = 2'h2;
    localparam logic [1:0] BDC_INT_TC   = 2'h3;

    // Destination unit size codes.
    localparam logic [1:0] BDC_USZ_BYTE = 2'h0;
    localparam logic [1:0] BDC_USZ_HALF = 2'h1;
    localparam logic [1:0] BDC_USZ_WORD = 2'h2;

    // Command, configuration and interrupt status bit positions.
    localparam int BDC_CMD_START  = 0;
    localparam int BDC_CMD_CANCEL = 1;
    localparam int BDC_CFG_RDIS   = 0;
    localparam int BDC_CFG_USZ    = 2;
    localparam int BDC_IST_XFER   = 0;
    localparam int BDC_IST_TC     = 1;

    localparam int BDC_CNT_W = 20;

    localparam logic [31:0] BDC_INIT_RESET = 32'h0400_0000;
    localparam logic [1:0]  BDC_RDIS_RESET = 2'h0;
    localparam logic [1:0]  BDC_USZ_RESET  = 2'h0;
    localparam logic [1:0]  BDC_IMSK_RESET = 2'h0;

    typedef struct packed {
        logic [1:0]           src;
        logic [1:0]           hs;
        logic [1:0]           unit_mode;
        logic [1:0]           otf;
        logic [1:0]           irq_mode;
        logic                 reload;
        logic                 en;
        logic [BDC_CNT_W-1:0] cnt;
    } bdc_ctrl_word_t;

    typedef enum logic {BDC_ST_IDLE, BDC_ST_XFER} bdc_state_t;

    // Count step for one moved unit.
    function automatic logic [BDC_CNT_W-1:0] bdc_unit_step(input logic [1:0] usz);
        case (usz)
            BDC_USZ_HALF: bdc_unit_step = 20'h00002;
            BDC_USZ_WORD: bdc_unit_step = 20'h00004;
            default:      bdc_unit_step = 20'h00001;
        endcase
    endfunction : bdc_unit_step

    // Count after one unit; stops at zero if the count was misprogrammed.
    function automatic logic [BDC_CNT_W-1:0] bdc_next_count(input logic [BDC_CNT_W-1:0] cnt,
                                                            input logic [1:0]           usz);
        if (cnt > bdc_unit_step(usz))
            bdc_next_count = cnt - bdc_unit_step(usz);
        else
            bdc_next_count = '0;
    endfunction : bdc_next_count

endpackage : bdc_pkg

// ===== src/bdc_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_ahb_slave
    import bdc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic             acc_pend,
    output logic             acc_write,
    output logic [7:0]       acc_addr
);

    typedef struct packed {
        logic       pend;
        logic       write;
        logic [7:0] addr;
        logic       ready;
    } bdc_ahb_st_t;

    bdc_ahb_st_t s_q;
    bdc_ahb_st_t s_d;

    // One wait state: the register access happens in the first data-phase cycle.
    always_comb
    begin
        s_d      = s_q;
        s_d.pend = 1'b0;
        s_d.ready = 1'b1;
        if (hsel && htrans[1] && hready)
        begin
            s_d.pend  = 1'b1;
            s_d.write = hwrite;
            s_d.addr  = {haddr[7:2], 2'h0};
            s_d.ready = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '{pend: 1'b0, write: 1'b0, addr: 8'h00, ready: 1'b1};
        else
            s_q <= s_d;
    end

    assign hreadyout = s_q.ready;
    assign hresp     = 1'b0;
    assign acc_pend  = s_q.pend;
    assign acc_write = s_q.write;
    assign acc_addr  = s_q.addr;

endmodule : bdc_ahb_slave
`default_nettype wire

// ===== src/bdc_count_unit.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_count_unit
    import bdc_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 load,
    input  wire logic [BDC_CNT_W-1:0] load_val,
    input  wire logic                 dec,
    input  wire logic [1:0]           usz,
    output logic [BDC_CNT_W-1:0]      count
);

    typedef struct packed {
        logic [BDC_CNT_W-1:0] cnt;
    } bdc_cnt_st_t;

    bdc_cnt_st_t s_q;
    bdc_cnt_st_t s_d;

    // A load, which is also the auto-reload, takes priority over a decrement.
    always_comb
    begin
        s_d = s_q;
        if (load)
            s_d.cnt = load_val;
        else if (dec)
            s_d.cnt = bdc_next_count(s_q.cnt, usz);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '{cnt: '0};
        else
            s_q <= s_d;
    end

    assign count = s_q.cnt;

endmodule : bdc_count_unit
`default_nettype wire

// ===== src/bdc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_channel
    import bdc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        req_timer,
    input  wire logic        req_uart,
    input  wire logic        req_sync,
    output logic [2:0]       req_ack,
    output logic             xfer_req,
    output logic [1:0]       xfer_unit_size,
    input  wire logic        xfer_done,
    output logic             irq
);

    typedef struct packed {
        bdc_state_t     state;
        bdc_ctrl_word_t ctrl;
        logic [1:0]     rdis;
        logic [1:0]     usz;
        logic           sw_run;
        logic           hw_xfer;
        logic [1:0]     ist;
        logic [1:0]     imsk;
        logic [31:0]    rdata;
        logic           irq;
        logic           xreq;
        logic [2:0]     ack;
    } bdc_top_st_t;

    bdc_top_st_t s_q;
    bdc_top_st_t s_d;

    logic                 acc_pend;
    logic                 acc_write;
    logic [7:0]           acc_addr;
    logic                 cnt_load;
    logic [BDC_CNT_W-1:0] cnt_load_val;
    logic                 cnt_dec;
    logic [BDC_CNT_W-1:0] cur_cnt;
    logic                 hw_req;
    logic                 tc;
    logic                 wr_init;
    logic                 wr_cmd;
    bdc_ctrl_word_t       wr_word;
    bdc_ctrl_word_t       cur_word;

    bdc_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .acc_pend  (acc_pend),
        .acc_write (acc_write),
        .acc_addr  (acc_addr)
    );

    bdc_count_unit u_cnt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (cnt_load),
        .load_val (cnt_load_val),
        .dec      (cnt_dec),
        .usz      (s_q.usz),
        .count    (cur_cnt)
    );

    // Only whole-word accesses are issued, so hsize needs no decoding.
    logic unused_hsize;
    assign unused_hsize = ^hsize;

    // Level of the selected request source.
    function automatic logic sel_req(input logic [1:0] src,
                                     input logic [2:0] reqs);
        case (src)
            BDC_SRC_TIMER: sel_req = reqs[0];
            BDC_SRC_UART:  sel_req = reqs[1];
            BDC_SRC_SYNC:  sel_req = reqs[2];
            default:       sel_req = 1'b0;
        endcase
    endfunction : sel_req

    // One-hot acknowledge for the selected source.
    function automatic logic [2:0] sel_ack(input logic [1:0] src);
        case (src)
            BDC_SRC_TIMER: sel_ack = 3'h1;
            BDC_SRC_UART:  sel_ack = 3'h2;
            BDC_SRC_SYNC:  sel_ack = 3'h4;
            default:       sel_ack = 3'h0;
        endcase
    endfunction : sel_ack

    // Forces the reserved mode fields to their only legal values.
    function automatic bdc_ctrl_word_t fix_modes(input bdc_ctrl_word_t w);
        fix_modes           = w;
        fix_modes.hs        = BDC_HANDSHAKE_MODE;
        fix_modes.unit_mode = BDC_UNIT_MODE;
        fix_modes.otf       = BDC_NO_FLY_MODE;
    endfunction : fix_modes

    // Write strobe of one register offset.
    function automatic logic reg_wr(input logic       pend,
                                    input logic       wr,
                                    input logic [7:0] addr,
                                    input logic [7:0] ofs);
        reg_wr = pend && wr && (addr == ofs);
    endfunction : reg_wr

    // The requester drops its level while acknowledged, so one level starts one unit.
    assign hw_req  = sel_req(s_q.ctrl.src, {req_sync, req_uart, req_timer});
    // Terminal count is a zero count after this unit; a short remainder also ends the run.
    assign tc      = (bdc_next_count(cur_cnt, s_q.usz) == '0);
    assign wr_init = reg_wr(acc_pend, acc_write, acc_addr, BDC_OFS_INIT);
    assign wr_cmd  = reg_wr(acc_pend, acc_write, acc_addr, BDC_OFS_CMD);
    assign wr_word = fix_modes(bdc_ctrl_word_t'(hwdata));

    // The current count view shares the control fields and shows the live count.
    always_comb
    begin
        cur_word     = fix_modes(s_q.ctrl);
        cur_word.cnt = cur_cnt;
    end

    always_comb
    begin
        s_d          = s_q;
        s_d.ack      = 3'h0;
        cnt_load     = 1'b0;
        cnt_load_val = s_q.ctrl.cnt;
        cnt_dec      = 1'b0;

        // Register writes; while a unit runs, an initial-count write changes the fields only.
        if (wr_init)
        begin
            s_d.ctrl = wr_word;
            if (s_q.state == BDC_ST_IDLE)
            begin
                cnt_load     = 1'b1;
                cnt_load_val = wr_word.cnt;
            end
        end
        if (acc_pend && acc_write)
        begin
            case (acc_addr)
                BDC_OFS_IMSK:
                    s_d.imsk = hwdata[1:0];
                BDC_OFS_CFG:
                begin
                    s_d.rdis = hwdata[BDC_CFG_RDIS +: 2];
                    s_d.usz = hwdata[BDC_CFG_USZ +: 2];
                end
                default:
                    s_d.imsk = s_d.imsk;
            endcase
        end

        // Register reads; the status register clears on read.
        if (acc_pend && !acc_write)
        begin
            case (acc_addr)
                BDC_OFS_INIT:
                    s_d.rdata = fix_modes(s_q.ctrl);
                BDC_OFS_CUR:
                    s_d.rdata = cur_word;
                BDC_OFS_IST:
                begin
                    s_d.rdata = {30'h0, s_q.ist};
                    s_d.ist   = 2'h0;
                end
                BDC_OFS_IMSK:
                    s_d.rdata = {30'h0, s_q.imsk};
                BDC_OFS_CFG:
                    s_d.rdata = {28'h0, s_q.usz, s_q.rdis};
                default:
                    s_d.rdata = 32'h0;
            endcase
        end

        // Start command arms software-driven transfers.
        if (wr_cmd && hwdata[BDC_CMD_START])
            s_d.sw_run = 1'b1;

        case (s_q.state)
            BDC_ST_IDLE:
            begin
                // A unit starts only while enabled; a start with enable low is dropped.
                if (s_q.ctrl.en)
                begin
                    if (s_q.sw_run || (s_q.rdis == 2'h0 && hw_req))
                    begin
                        s_d.state   = BDC_ST_XFER;
                        s_d.xreq    = 1'b1;
                        s_d.hw_xfer = !s_q.sw_run && hw_req;
                    end
                end
                else
                    s_d.sw_run = 1'b0;
            end
            BDC_ST_XFER:
            begin
                if (xfer_done)
                begin
                    s_d.state = BDC_ST_IDLE;
                    s_d.xreq  = 1'b0;
                    cnt_dec   = 1'b1;
                    if (s_q.hw_xfer)
                        s_d.ack = sel_ack(s_q.ctrl.src);
                    if (s_q.ctrl.irq_mode == BDC_INT_EACH)
                        s_d.ist[BDC_IST_XFER] = 1'b1;
                    if (tc)
                    begin
                        s_d.sw_run = 1'b0;
                        if (s_q.ctrl.irq_mode == BDC_INT_TC)
                            s_d.ist[BDC_IST_TC] = 1'b1;
                        if (s_q.ctrl.reload)
                        begin
                            cnt_load     = 1'b1;
                            cnt_load_val = s_d.ctrl.cnt;
                        end
                        else
                            s_d.ctrl.en = 1'b0;
                    end
                end
            end
            default:
                s_d.state = BDC_ST_IDLE;
        endcase

        // Cancel overrides state, request, ack and enable; a same-cycle status flag or count reload still applies.
        if (wr_cmd && hwdata[BDC_CMD_CANCEL])
        begin
            s_d.state   = BDC_ST_IDLE;
            s_d.xreq    = 1'b0;
            s_d.sw_run  = 1'b0;
            s_d.hw_xfer = 1'b0;
            s_d.ack     = 3'h0;
            s_d.ctrl.en = 1'b0;
            cnt_dec     = 1'b0;
        end

        s_d.irq = |(s_d.ist & s_d.imsk);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '{state:   BDC_ST_IDLE,
                     ctrl:    bdc_ctrl_word_t'(BDC_INIT_RESET),
                     rdis:    BDC_RDIS_RESET,
                     usz:     BDC_USZ_RESET,
                     sw_run:  1'b0,
                     hw_xfer: 1'b0,
                     ist:     2'h0,
                     imsk:    BDC_IMSK_RESET,
                     rdata:   32'h0,
                     irq:     1'b0,
                     xreq:    1'b0,
                     ack:     3'h0};
        else
            s_q <= s_d;
    end

    assign hrdata         = s_q.rdata;
    assign req_ack        = s_q.ack;
    assign xfer_req       = s_q.xreq;
    assign xfer_unit_size = s_q.usz;
    assign irq            = s_q.irq;

endmodule : bdc_channel
`default_nettype wire

// ===== sim/bdc_channel_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_channel_checker
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [2:0] req_ack,
    input wire logic       xfer_req,
    input wire logic       xfer_done,
    input wire logic       irq
);
    logic dph_q;
    logic wr_q;

    // Marks the data phase of an accepted transfer and whether it writes.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_q <= 1'b0;
            wr_q  <= 1'b0;
        end
        else
        begin
            dph_q <= hsel && htrans[1] && hready;
            wr_q  <= hwrite;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("bus response is not OKAY");
    AST_ONE_WAIT: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
        else $error("wait state is not exactly one cycle");
    AST_DONE_DROPS: assert property (xfer_req && xfer_done |=> !xfer_req)
        else $error("unit request stays after completion");
    AST_IDLE_GAP: assert property (
        $fell(xfer_req) |-> $past(xfer_done || (dph_q && wr_q)))
        else $error("unit request fell without completion or cancel");
    AST_REQ_HOLD: assert property (xfer_req && !xfer_done && !(dph_q && wr_q) |=> xfer_req)
        else $error("unit request dropped without cause");
    AST_ACK_CAUSE: assert property (req_ack != 3'h0 |-> $past(xfer_req && xfer_done))
        else $error("acknowledge without a finished unit");
    AST_ACK_PULSE: assert property (req_ack != 3'h0 |=> req_ack == 3'h0)
        else $error("acknowledge longer than one cycle");
    AST_ACK_ONEHOT: assert property ($onehot0(req_ack))
        else $error("more than one source acknowledged");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(dph_q) || $past(dph_q, 2))
        else $error("interrupt fell without a register access");

    COV_ACK: cover property (req_ack[0]);
    COV_IRQ: cover property ($rose(irq));
    COV_UNIT: cover property (xfer_req && xfer_done);
endmodule : bdc_channel_checker
bind bdc_channel bdc_channel_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .req_ack, .xfer_req, .xfer_done, .irq);
`default_nettype wire

// ===== sim/bdc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_periph_model
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] arm,
    input  wire logic [3:0] delay,
    input  wire logic [2:0] req_ack,
    input  wire logic       xfer_req,
    output logic            req_timer,
    output logic            req_uart,
    output logic            req_sync,
    output logic            xfer_done,
    output logic [23:0]     ack_cnt
);
    logic [2:0] req_q;
    logic [3:0] wait_q;

    // A request level falls in the very cycle its acknowledge shows.
    assign {req_sync, req_uart, req_timer} = req_q & ~req_ack;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_q     <= 3'h0;
            wait_q    <= 4'h0;
            xfer_done <= 1'b0;
            ack_cnt   <= 24'h0;
        end
        else
        begin
            req_q     <= (req_q | arm) & ~req_ack;
            xfer_done <= 1'b0;
            wait_q    <= 4'h0;
            if (xfer_req && !xfer_done)
            begin
                if (wait_q >= delay)
                    xfer_done <= 1'b1;
                else
                    wait_q <= wait_q + 4'h1;
            end
            for (int i = 0; i < 3; i++)
                if (req_ack[i])
                    ack_cnt[8*i+:8] <= ack_cnt[8*i+:8] + 8'h01;
        end
    end
endmodule : bdc_periph_model
`default_nettype wire

// ===== sim/bridge_dma_channel_count_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module bridge_dma_channel_count_control_bench
    import bdc_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  arm = 3'h0;
    logic [3:0]  delay = 4'h0;
    logic [31:0] rd;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, xfer_req, xfer_done, irq, req_timer, req_uart, req_sync;
    logic [2:0]  req_ack;
    logic [1:0]  usz;
    logic [23:0] acks;
    int          errors = 0;
    int          total_checks = 0;
    int          cyc = 0;

    always #50 hclk = ~hclk;

    bdc_channel dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .req_timer, .req_uart, .req_sync,
        .req_ack, .xfer_req, .xfer_unit_size(usz), .xfer_done, .irq);
    bdc_periph_model u_far (.hclk, .hresetn, .arm, .delay, .req_ack, .xfer_req, .req_timer,
        .req_uart, .req_sync, .xfer_done, .ack_cnt(acks));

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        ahb(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask : rchk

    function automatic logic [31:0] fw(input logic [1:0] s, input logic [1:0] i, input logic r,
                                       input logic en, input logic [19:0] c);
        fw = {s, BDC_HANDSHAKE_MODE, BDC_UNIT_MODE, BDC_NO_FLY_MODE, i, r, en, c};
    endfunction : fw

    task automatic prog(input logic [31:0] w);
        ahb(1'b1, BDC_OFS_INIT, w & ~32'h0010_0000);
        ahb(1'b1, BDC_OFS_INIT, w | 32'h0010_0000);
    endtask : prog

    task automatic pulse(input logic [2:0] m);
        arm <= m;
        @(posedge hclk);
        arm <= 3'h0;
    endtask : pulse

    // Returns once no unit has been requested for eight cycles.
    task automatic quiet;
        int q;
        q = 0;
        while (q < 8)
        begin
            @(posedge hclk);
            q = xfer_req ? 0 : q + 1;
        end
    endtask : quiet

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(BDC_OFS_INIT, BDC_INIT_RESET, "init reset");
        rchk(BDC_OFS_CUR, BDC_INIT_RESET, "cur reset");
        rchk(BDC_OFS_CFG, 32'h0, "cfg reset");
        `CHK("okay", 1'b0, hresp)
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rchk(8'h20, 32'h0, "unmapped");
        ahb(1'b1, BDC_OFS_CUR, 32'hFFFF_FFFF);
        rchk(BDC_OFS_CUR, BDC_INIT_RESET, "cur read only");
        $display("test reset done");

        ahb(1'b1, BDC_OFS_IMSK, 32'h3);
        ahb(1'b1, BDC_OFS_INIT, fw(BDC_SRC_NONE, BDC_INT_EACH, 1'b0, 1'b0, 20'h3));
        ahb(1'b1, BDC_OFS_CMD, 32'h1);
        quiet();
        prog(fw(BDC_SRC_NONE, BDC_INT_EACH, 1'b0, 1'b1, 20'h3));
        quiet();
        rchk(BDC_OFS_CUR, fw(BDC_SRC_NONE, BDC_INT_EACH, 1'b0, 1'b1, 20'h3), "no run");
        delay <= 4'h2;
        ahb(1'b1, BDC_OFS_CMD, 32'h1);
        quiet();
        rchk(BDC_OFS_CUR, fw(BDC_SRC_NONE, BDC_INT_EACH, 1'b0, 1'b0, 20'h0), "sw end");
        `CHK("irq each", 1'b1, irq)
        rchk(BDC_OFS_IST, 32'h1, "ist each");
        rchk(BDC_OFS_IST, 32'h0, "ist cleared");
        `CHK("irq cleared", 1'b0, irq)
        $display("test software start done");

        delay <= 4'h0;
        ahb(1'b1, BDC_OFS_CFG, 32'h8);
        prog(fw(BDC_SRC_TIMER, BDC_INT_TC, 1'b1, 1'b1, 20'h8));
        pulse(3'h1);
        quiet();
        `CHK("unit size", BDC_USZ_WORD, usz)
        rchk(BDC_OFS_CUR, fw(BDC_SRC_TIMER, BDC_INT_TC, 1'b1, 1'b1, 20'h4), "word");
        rchk(BDC_OFS_IST, 32'h0, "ist no tc");
        pulse(3'h1);
        quiet();
        rchk(BDC_OFS_CUR, fw(BDC_SRC_TIMER, BDC_INT_TC, 1'b1, 1'b1, 20'h8), "reload");
        rchk(BDC_OFS_IST, 32'h2, "ist tc");
        ahb(1'b1, BDC_OFS_CMD, 32'h1);
        quiet();
        rchk(BDC_OFS_CUR, fw(BDC_SRC_TIMER, BDC_INT_TC, 1'b1, 1'b1, 20'h8), "restart");
        `CHK("timer acks", 8'h02, acks[7:0])
        rchk(BDC_OFS_IST, 32'h2, "ist tc again");
        ahb(1'b1, BDC_OFS_CMD, 32'h2);
        $display("test auto reload done");

        ahb(1'b1, BDC_OFS_CFG, 32'h4);
        for (int s = 0; s < 4; s++)
        begin
            prog(fw(s[1:0], BDC_INT_POLL, 1'b0, 1'b1, 20'h2));
            if (s == 0)
            begin
                pulse(3'h7);
                quiet();
                rchk(BDC_OFS_CUR, fw(2'h0, BDC_INT_POLL, 1'b0, 1'b1, 20'h2), "none");
                delay <= 4'hF;
                ahb(1'b1, BDC_OFS_CMD, 32'h1);
                ahb(1'b0, BDC_OFS_CFG, 32'h0);
                `CHK("running", 1'b1, xfer_req)
                ahb(1'b1, BDC_OFS_CMD, 32'h3);
                `CHK("aborted", 1'b0, xfer_req)
                rchk(BDC_OFS_CUR, fw(2'h0, BDC_INT_POLL, 1'b0, 1'b0, 20'h2), "cancel");
                delay <= 4'h0;
            end
            else
            begin
                quiet();
                rchk(BDC_OFS_CUR, fw(s[1:0], BDC_INT_POLL, 1'b0, 1'b0, 20'h0), "src");
                `CHK("acks", (s == 1) ? 8'h03 : 8'h01, acks[8*(s-1)+:8])
            end
        end
        `CHK("irq poll", 1'b0, irq)
        $display("test sources done");
        test_done();
    end
endmodule : bridge_dma_channel_count_control_bench
`default_nettype wire
